// *** mtsf_pkg.sv ***
`default_nettype none
package mtsf_pkg;
    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_EVENT = 8'h10;
    localparam logic [7:0] ADDR_GLOBAL = 8'h12;
    localparam logic [7:0] ADDR_LIGHT = 8'h13;
    localparam logic [7:0] ADDR_RAW_HI = 8'h22;
    localparam logic [7:0] ADDR_RAW_LO = 8'h23;
    localparam logic [7:0] ADDR_PDS_HI = 8'h34;
    localparam logic [7:0] ADDR_PDS_LO = 8'h35;
    localparam logic [7:0] ADDR_NDS_HI = 8'h36;
    localparam logic [7:0] ADDR_NDS_LO = 8'h37;
    localparam logic [7:0] ADDR_NEAR_THR = 8'h60;
    localparam logic [7:0] ADDR_CONTACT_THR = 8'h61;
    localparam logic [7:0] ADDR_MOTION_CFG = 8'h90;
    localparam logic [7:0] ADDR_ENTER_THR = 8'h91;
    localparam logic [7:0] ADDR_EXIT_THR = 8'h92;
    localparam logic [7:0] ADDR_SCALE = 8'h93;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int EV_TOUCH_BIT = 0;
    localparam int EV_MOTION_BIT = 1;
    localparam int GL_NEAR_BIT = 0;
    localparam int GL_CONTACT_BIT = 1;
    localparam int GL_MOTION_BIT = 3;
    localparam int LT_RISING_BIT = 3;
    localparam int LT_RAMPING_BIT = 4;
    localparam int CFG_IGNORE_POL_BIT = 0;

    // ----------------------------------------------------------------
    // reset values and sum saturation limit
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_NEAR_THR = 8'h08;
    localparam logic [7:0] RST_CONTACT_THR = 8'h10;
    localparam logic [7:0] RST_MOTION_CFG = 8'h01;
    localparam logic [7:0] RST_ENTER_THR = 8'h10;
    localparam logic [7:0] RST_EXIT_THR = 8'h08;
    localparam logic [7:0] RST_SCALE = 8'h04;
    localparam logic [15:0] SUM_MAX = 16'hFFFF;

    typedef enum logic {MTSF_ARMED, MTSF_LATCHED} mtsf_motion_e;
endpackage : mtsf_pkg
`default_nettype wire

// *** mtsf_delta_sum.sv ***
`default_nettype none
module mtsf_delta_sum #(
    parameter int LEAK_SHIFT = 3
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sampleValid,
    input wire logic [15:0] step,
    output logic [15:0] sum,
    output logic [15:0] next_sum
);
    import mtsf_pkg::*;

    logic [16:0] grown;

    // leak a fraction, then add this sample's step, saturating
    always_comb begin
        grown = {1'b0, sum - (sum >> LEAK_SHIFT)} + {1'b0, step};
        next_sum = sum;
        if (sampleValid) begin
            next_sum = grown[16] ? SUM_MAX : grown[15:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sum <= RST_WORD;
        end else begin
            sum <= next_sum;
        end
    end
endmodule : mtsf_delta_sum
`default_nettype wire

// *** mtsf_status.sv ***
`default_nettype none
// What this block does
// - event flags bit 1 set when motion detected.
// - event flags bit 0 set when touch becomes active.
// - global flags bit 3 set when a motion event occurred.
// - global flags bit 0 shows near, bit 1 shows contact.
// - lighting bit 4 high while output level changes.
// - lighting bit 3 set on rising duty, cleared on falling.
// - raw motion count readable as high and low bytes.
// - delta is previous count minus current count.
// - positive delta sum grows when count increases.
// - negative delta sum grows when count decreases.
// - motion event when the positive sum (either sum if config bit 0 is set) exceeds enter times scale.
// - no new event until sums fall below exit times scale.
module mtsf_status #(
    parameter int LEAK_SHIFT = 3
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sampleValid,
    input wire logic [15:0] sampleCount,
    input wire logic [7:0] touchDelta,
    input wire logic [7:0] pwmDuty,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic motionActive
);
    import mtsf_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] nearThr, contactThr, motionCfg, enterThr, exitThr, scale;
    logic [7:0] next_nearThr, next_contactThr, next_motionCfg;
    logic [7:0] next_enterThr, next_exitThr, next_scale;
    logic [7:0] eventFlags, globalFlags, lightFlags;
    logic [7:0] next_eventFlags, next_globalFlags, next_lightFlags;
    logic [15:0] rawCount, next_rawCount;
    logic [7:0] prevDuty, next_prevDuty;
    logic [7:0] next_regRdata;
    logic primed, next_primed;
    mtsf_motion_e motionState, next_motionState;
    logic [15:0] delta, posStep, negStep, posSum, negSum;
    logic [15:0] next_posSum, next_negSum;
    logic [15:0] enterLevel, exitLevel;
    logic nearNow, contactNow, crossed, belowExit, motionHit;

    // ----------------------------------------------------------------
    // delta accumulation
    // ----------------------------------------------------------------
    // delta from counts
    always_comb begin
        delta = rawCount - sampleCount;
        posStep = 16'h0000;
        negStep = 16'h0000;
        if (primed && sampleCount > rawCount) begin
            posStep = sampleCount - rawCount;
        end
        if (primed && sampleCount < rawCount) begin
            negStep = delta;
        end
    end

    mtsf_delta_sum #(.LEAK_SHIFT(LEAK_SHIFT)) posAcc (
        .mclk(mclk),
        .nrst(nrst),
        .sampleValid(sampleValid),
        .step(posStep),
        .sum(posSum),
        .next_sum(next_posSum)
    );

    mtsf_delta_sum #(.LEAK_SHIFT(LEAK_SHIFT)) negAcc (
        .mclk(mclk),
        .nrst(nrst),
        .sampleValid(sampleValid),
        .step(negStep),
        .sum(negSum),
        .next_sum(next_negSum)
    );

    // ----------------------------------------------------------------
    // detection and flag next values
    // ----------------------------------------------------------------
    always_comb begin
        enterLevel = 16'(enterThr * scale);
        exitLevel = 16'(exitThr * scale);
        // polarity option
        // compare the sums this sample produces, so flags match the sums read back
        crossed = (next_posSum > enterLevel)
            || (motionCfg[CFG_IGNORE_POL_BIT] && (next_negSum > enterLevel));
        belowExit = (next_posSum < exitLevel) && (next_negSum < exitLevel);
        motionHit = (motionState == MTSF_ARMED) && crossed;
        nearNow = touchDelta > nearThr;
        contactNow = touchDelta > contactThr;

        next_motionState = motionState;
        next_eventFlags = eventFlags;
        next_globalFlags = globalFlags;
        next_lightFlags = lightFlags;
        next_rawCount = rawCount;
        next_prevDuty = prevDuty;
        next_primed = primed;
        if (sampleValid) begin
            next_primed = 1'b1;
            next_rawCount = sampleCount;
            next_prevDuty = pwmDuty;
            unique case (motionState)
                MTSF_ARMED: begin
                    if (crossed) begin
                        next_motionState = MTSF_LATCHED;
                    end
                end
                MTSF_LATCHED: begin
                    if (belowExit) begin
                        next_motionState = MTSF_ARMED;
                    end
                end
            endcase
            next_eventFlags = RST_BYTE;
            next_eventFlags[EV_MOTION_BIT] = motionHit;
            next_eventFlags[EV_TOUCH_BIT] = contactNow && !globalFlags[GL_CONTACT_BIT];
            next_globalFlags = RST_BYTE;
            next_globalFlags[GL_NEAR_BIT] = nearNow;
            next_globalFlags[GL_CONTACT_BIT] = contactNow;
            next_globalFlags[GL_MOTION_BIT] = motionHit;
            next_lightFlags[LT_RAMPING_BIT] = primed && (pwmDuty != prevDuty);
            if (primed && pwmDuty > prevDuty) begin
                next_lightFlags[LT_RISING_BIT] = 1'b1;
            end else if (primed && pwmDuty < prevDuty) begin
                next_lightFlags[LT_RISING_BIT] = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    always_comb begin
        next_nearThr = nearThr;
        next_contactThr = contactThr;
        next_motionCfg = motionCfg;
        next_enterThr = enterThr;
        next_exitThr = exitThr;
        next_scale = scale;
        if (regWrite) begin
            unique case (regAddr)
                ADDR_NEAR_THR: next_nearThr = regWdata;
                ADDR_CONTACT_THR: next_contactThr = regWdata;
                ADDR_MOTION_CFG: next_motionCfg = regWdata;
                ADDR_ENTER_THR: next_enterThr = regWdata;
                ADDR_EXIT_THR: next_exitThr = regWdata;
                ADDR_SCALE: next_scale = regWdata;
                default: next_scale = scale;
            endcase
        end
        next_regRdata = regRdata;
        if (regRead) begin
            unique case (regAddr)
                ADDR_EVENT: next_regRdata = eventFlags;
                ADDR_GLOBAL: next_regRdata = globalFlags;
                ADDR_LIGHT: next_regRdata = lightFlags;
                ADDR_RAW_HI: next_regRdata = rawCount[15:8];
                ADDR_RAW_LO: next_regRdata = rawCount[7:0];
                ADDR_PDS_HI: next_regRdata = posSum[15:8];
                ADDR_PDS_LO: next_regRdata = posSum[7:0];
                ADDR_NDS_HI: next_regRdata = negSum[15:8];
                ADDR_NDS_LO: next_regRdata = negSum[7:0];
                ADDR_NEAR_THR: next_regRdata = nearThr;
                ADDR_CONTACT_THR: next_regRdata = contactThr;
                ADDR_MOTION_CFG: next_regRdata = motionCfg;
                ADDR_ENTER_THR: next_regRdata = enterThr;
                ADDR_EXIT_THR: next_regRdata = exitThr;
                ADDR_SCALE: next_regRdata = scale;
                default: next_regRdata = RST_BYTE;
            endcase
        end
    end

    // register all state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nearThr <= RST_NEAR_THR;
            contactThr <= RST_CONTACT_THR;
            motionCfg <= RST_MOTION_CFG;
            enterThr <= RST_ENTER_THR;
            exitThr <= RST_EXIT_THR;
            scale <= RST_SCALE;
            eventFlags <= RST_BYTE;
            globalFlags <= RST_BYTE;
            lightFlags <= RST_BYTE;
            rawCount <= RST_WORD;
            prevDuty <= RST_BYTE;
            primed <= 1'b0;
            motionState <= MTSF_ARMED;
            regRdata <= RST_BYTE;
            motionActive <= 1'b0;
        end else begin
            nearThr <= next_nearThr;
            contactThr <= next_contactThr;
            motionCfg <= next_motionCfg;
            enterThr <= next_enterThr;
            exitThr <= next_exitThr;
            scale <= next_scale;
            eventFlags <= next_eventFlags;
            globalFlags <= next_globalFlags;
            lightFlags <= next_lightFlags;
            rawCount <= next_rawCount;
            prevDuty <= next_prevDuty;
            primed <= next_primed;
            motionState <= next_motionState;
            regRdata <= next_regRdata;
            motionActive <= (next_motionState == MTSF_LATCHED); // latched motion state
        end
    end
endmodule : mtsf_status
`default_nettype wire

// *** mtsf_status_checker.sv ***
`default_nettype none
module mtsf_status_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sampleValid,
    input wire logic [15:0] sampleCount,
    input wire logic [7:0] touchDelta,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regRdata,
    input wire logic motionActive
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cntHi, next_cntHi, lastTouch, next_lastTouch;
    logic prevMa, next_prevMa, evFresh, next_evFresh;
    // ----
    // last sample seen and fresh motion event
    // ----
    always_comb begin
        next_cntHi = sampleValid ? sampleCount[15:8] : cntHi;
        next_lastTouch = sampleValid ? touchDelta : lastTouch;
        next_prevMa = motionActive;
        next_evFresh = sampleValid ? 1'b0 : (evFresh | (motionActive & ~prevMa));
    end
    // register the helpers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cntHi <= 8'h00;
            lastTouch <= 8'h00;
            prevMa <= 1'b0;
            evFresh <= 1'b0;
        end else begin
            cntHi <= next_cntHi;
            lastTouch <= next_lastTouch;
            prevMa <= next_prevMa;
            evFresh <= next_evFresh;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_hold; !regRead |=> $stable(regRdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_msv; !sampleValid |=> $stable(motionActive); endproperty
    a_msv: assert property (p_msv) else $error("motion moved");
    property p_evz; regRead && regAddr == 8'h10 |=> regRdata[7:2] == 6'h00; endproperty
    a_evz: assert property (p_evz) else $error("event bits set");
    property p_evm; regRead && regAddr == 8'h10 && evFresh |=> regRdata[1]; endproperty
    a_evm: assert property (p_evm) else $error("event flag low");
    property p_glm; regRead && regAddr == 8'h12 && evFresh |=> regRdata[3]; endproperty
    a_glm: assert property (p_glm) else $error("global flag low");
    property p_gli;
        regRead && regAddr == 8'h12 && lastTouch == 8'h00 |=> regRdata[1:0] == 2'b00;
    endproperty
    a_gli: assert property (p_gli) else $error("level flags set");
    property p_ltz;
        regRead && regAddr == 8'h13 |=> regRdata[7:5] == 3'h0 && regRdata[2:0] == 3'h0;
    endproperty
    a_ltz: assert property (p_ltz) else $error("lighting bits set");
    property p_raw; regRead && regAddr == 8'h22 |=> regRdata == $past(cntHi); endproperty
    a_raw: assert property (p_raw) else $error("raw count wrong");
endmodule : mtsf_status_checker
bind mtsf_status mtsf_status_checker i_chk (.mclk(mclk), .nrst(nrst),
    .sampleValid(sampleValid), .sampleCount(sampleCount), .touchDelta(touchDelta),
    .regRead(regRead), .regAddr(regAddr), .regRdata(regRdata), .motionActive(motionActive));
`default_nettype wire

// *** mtsf_host_model.sv ***
`default_nettype none
module mtsf_host_model #(
    parameter logic [7:0] CAP_CFG = 8'h00,
    parameter logic [7:0] MOTION_CFG = 8'h00,
    parameter logic [7:0] TUNE_CFG = 8'h00
) (
    input wire logic mclk,
    input wire logic [7:0] regRdata,
    output logic regRead = 1'b0,
    output logic regWrite = 1'b0,
    output logic [7:0] regAddr = 8'h00,
    output logic [7:0] regWdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // register access
    // ----
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~v;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        regAddr <= ~a;
        #1 v = regRdata;
    endtask : rd
    // recommended configuration
    task automatic setup();
        wr(8'h50, CAP_CFG);
        wr(8'h51, MOTION_CFG);
        wr(8'h54, TUNE_CFG);
        wr(8'h55, TUNE_CFG);
        wr(8'h60, 8'h08);
        wr(8'h61, 8'h10);
        wr(8'h90, 8'h01);
        wr(8'h91, 8'h04);
        wr(8'h92, 8'h02);
        wr(8'h93, 8'h01);
    endtask : setup
endmodule : mtsf_host_model
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic sampleValid = 1'b0;
    logic [15:0] sampleCount = 16'h0000;
    logic [7:0] touchDelta = 8'h00;
    logic [7:0] pwmDuty = 8'h00;
    logic regRead, regWrite, motionActive;
    logic [7:0] regAddr, regWdata, regRdata, d;
    int nMismatch = 0;
    int numChecks = 0;
    localparam logic [15:0] TAB [16] = '{16'h6008, 16'h6110, 16'h9001, 16'h9110, 16'h9208,
        16'h9304, 16'h1000, 16'h2200, 16'h3500, 16'h0000, 16'h6008, 16'h6110, 16'h9001,
        16'h9104, 16'h9202, 16'h9301};
    localparam logic [7:0] ADR [7] = '{8'h10, 8'h12, 8'h13, 8'h22, 8'h23, 8'h35, 8'h37};
    // read bytes in ADR order, then touch, duty, motion level
    localparam logic [79:0] ROW [8] = '{80'h00000010000000002000, 80'h02091810101000094001,
        80'h01031010100800113001, 80'h00030010100400113001, 80'h00001810100200005001,
        80'h00000810100100005000, 80'h00000810100100005000, 80'h02080810000110005001};
    // ----
    // clock, design and host
    // ----
    always #10 mclk = ~mclk;
    mtsf_status #(.LEAK_SHIFT(1)) i_dut (.mclk(mclk), .nrst(nrst), .sampleValid(sampleValid),
        .sampleCount(sampleCount), .touchDelta(touchDelta), .pwmDuty(pwmDuty),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .motionActive(motionActive));
    mtsf_host_model i_host (.mclk(mclk), .regRdata(regRdata), .regRead(regRead),
        .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        if (nMismatch == 0 && numChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // one sensing cycle
    task automatic smp(input logic [79:0] r);
        @(posedge mclk);
        sampleValid <= 1'b1;
        sampleCount <= r[55:40];
        touchDelta <= r[23:16];
        pwmDuty <= r[15:8];
        @(posedge mclk);
        sampleValid <= 1'b0;
    endtask : smp
    // main sequence
    initial begin
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            if (i == 10) begin
                i_host.setup();
            end
            i_host.rd(TAB[i][15:8], d);
            chk($sformatf("reg %h", TAB[i][15:8]), d, TAB[i][7:0]);
        end
        for (int i = 0; i < 8; i++) begin
            smp(ROW[i]);
            i_host.wr(ADR[i % 7], 8'hFF);
            for (int j = 0; j < 7; j++) begin
                i_host.rd(ADR[j], d);
                chk($sformatf("reg %h", ADR[j]), d, ROW[i][79 - 8 * j -: 8]);
            end
            chk("motionActive", {7'h00, motionActive}, {7'h00, ROW[i][0]});
        end
        i_host.rd(8'h34, d);
        chk("reg 34", d, 8'h00);
        i_host.rd(8'h36, d);
        chk("reg 36", d, 8'h00);
        close_out();
    end
    // hang guard
    initial begin
        repeat (3000) @(posedge mclk);
        nMismatch++;
        close_out();
    end
endmodule : testbench
`default_nettype wire
